// file: design/chg_irq_pkg.sv
// Constants, types and register map of the charger interrupt and status bank
//Contract
// - Event bit sets when its status changes
// - Reading event flags clears them
// - Pending indication drops when no flags remain
// - Mask one blocks pin; masks reset high
// - Same bit position across three registers
// - Bit order: bypass to mode, zero to seven
// - Bypass good only when detail is zero
// - Battery good for codes three or four
// - Charger good for codes 0,1,2,3,5,8
// - Topoff flag follows topoff state
// - Input good only for code three
// - Mode flag high when no limiting
// - Overcurrent flag follows overcurrent limit
// - Presence flag high when battery present
// - Detail bit zero is inverted presence
// - Detail bit one shows overvoltage switch
// - Detail bit two shows bus comparator
// - Two-bit input detail field encoding
// - Lock blocks writes to static configuration
// - Aggregated pending flag reported as bit zero
package chg_irq_pkg;

    // Register offsets on the charger slave
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hB0;
    localparam logic [7:0] ADDR_EVENT_MASKS = 8'hB1;
    localparam logic [7:0] ADDR_HEALTH_FLAGS = 8'hB2;
    localparam logic [7:0] ADDR_DETAIL_ZERO = 8'hB3;
    localparam logic [7:0] ADDR_DETAIL_ONE = 8'hB4;
    localparam logic [7:0] ADDR_CFG_FIRST = 8'hB8;
    localparam logic [7:0] ADDR_CFG_LAST_RUN = 8'hBC;
    localparam logic [7:0] ADDR_CFG_SEVEN = 8'hBE;

    // Reset values
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_EVENT_MASKS = 8'hFF;
    localparam logic [7:0] RST_PREV_STATUS = 8'h00;
    localparam int CFG_COUNT = 6;
    localparam int CFG_SEVEN_INDEX = 5;
    // Entries 01..05 then 07; unknown values default to zero
    localparam logic [47:0] RST_STATIC_CFG = {8'h00, 8'h00, 8'h00, 8'hDA, 8'h09, 8'hD8};

    // Shared bit positions of flags, masks and health
    localparam int BIT_BYPASS = 0;
    localparam int BIT_OVERCURRENT = 1;
    localparam int BIT_PRESENT = 2;
    localparam int BIT_BATTERY = 3;
    localparam int BIT_CHARGER = 4;
    localparam int BIT_TOPOFF = 5;
    localparam int BIT_INPUT = 6;
    localparam int BIT_MODE = 7;

    // Detail code values
    localparam logic [2:0] BYPASS_CLEAN = 3'h0;
    localparam logic [2:0] BATT_OK_HIGH = 3'h3;
    localparam logic [2:0] BATT_OK_LOW = 3'h4;
    localparam logic [1:0] INPUT_UNDER_UVLO = 2'h0;
    localparam logic [1:0] INPUT_BELOW_BATT = 2'h1;
    localparam logic [1:0] INPUT_OVER_OVLO = 2'h2;
    localparam logic [1:0] INPUT_VALID = 2'h3;
    // One bit per charger detail code that counts as good
    localparam logic [15:0] CHG_GOOD_CODES = 16'h012F;

    // Serial slave address of the charger register page
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Raw analog status from charger comparators and state machine
    typedef struct packed {
        logic [2:0] bypass_detail_code;
        logic batt_overcurrent;
        logic battery_present;
        logic [2:0] battery_detail_code;
        logic [3:0] charger_detail_code;
        logic topoff_state;
        logic [1:0] input_detail_code;
        logic adaptive_input_limit;
        logic input_current_limit_mode;
        logic overvoltage_switch_on;
        logic bus_below_threshold;
    } analog_status_t;

    localparam int STATUS_W = $bits(analog_status_t);
    // Status, lock, clock and data of the serial port
    localparam int SYNC_W = STATUS_W + 3;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_DEV = 9'h002,
        ST_DEV_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WR = 9'h020,
        ST_WR_ACK = 9'h040,
        ST_RD = 9'h080,
        ST_RD_ACK = 9'h100
    } serial_state_t;

endpackage

// file: design/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module pin_sync
    import chg_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [SYNC_W-1:0] i_async,
    output logic [SYNC_W-1:0] o_sync
);
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] mid_ff;
    logic [SYNC_W-1:0] late_ff;
    logic [SYNC_W-1:0] held_ff;

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_bit
            // Second and third stage must agree before a change is taken
            wire agree = (mid_ff[g] == late_ff[g]);
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_ff[g] <= 1'b0;
                    mid_ff[g] <= 1'b0;
                    late_ff[g] <= 1'b0;
                    held_ff[g] <= 1'b0;
                end else begin
                    meta_ff[g] <= i_async[g];
                    mid_ff[g] <= meta_ff[g];
                    late_ff[g] <= mid_ff[g];
                    held_ff[g] <= agree ? late_ff[g] : held_ff[g];
                end
            end
        end
    endgenerate

    assign o_sync = held_ff;
endmodule

// file: design/change_flags.sv
// Change-detect event flags with clear-on-read, one per status bit
`timescale 1ns/1ps
module change_flags
    import chg_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_status,
    input wire logic i_clear,
    output logic [7:0] o_flags
);
    logic primed_ff;
    logic [7:0] prev_ff;
    logic [7:0] flags_ff;

    // First cycle after reset only learns the status, so no false event
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            primed_ff <= 1'b0;
        end else begin
            primed_ff <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_flag
            wire changed = primed_ff && (i_status[g] != prev_ff[g]);
            // Set beats clear so a change during the read survives
            wire nxt_flag = changed | (flags_ff[g] & ~i_clear);
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    prev_ff[g] <= RST_PREV_STATUS[g];
                    flags_ff[g] <= RST_EVENT_FLAGS[g];
                end else begin
                    prev_ff[g] <= i_status[g];
                    flags_ff[g] <= nxt_flag;
                end
            end
        end
    endgenerate

    assign o_flags = flags_ff;
endmodule

// file: design/charger_interrupt_status_bank.sv
// Charger event, mask, health and detail registers behind the serial slave
`timescale 1ns/1ps
module charger_interrupt_status_bank
    import chg_irq_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire analog_status_t I_ANALOG_STATUS,
    input wire logic I_STATIC_WRITE_LOCK,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    output logic O_CHARGER_IRQ_N,
    output logic O_TOP_CHARGER_PENDING,
    output logic [47:0] O_STATIC_CONFIG
);
    // Reset release
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Every pin but reset is filtered through one synchroniser bank
    logic [SYNC_W-1:0] sync_bus;
    analog_status_t status_s;
    logic static_write_lock;
    logic scl_s;
    logic sda_s;

    pin_sync u_pin_sync (
        .i_clk(I_CLOCK),
        .i_rst_n(rst_n_ff),
        .i_async({I_STATIC_WRITE_LOCK, I_SCL, I_SDA, I_ANALOG_STATUS}),
        .o_sync(sync_bus)
    );

    assign status_s = analog_status_t'(sync_bus[STATUS_W-1:0]);
    assign sda_s = sync_bus[STATUS_W];
    assign scl_s = sync_bus[STATUS_W+1];
    assign static_write_lock = sync_bus[STATUS_W+2];

    // Single-bit health view, same positions as flags and masks
    logic [7:0] health;
    logic [7:0] detail_zero;
    logic [7:0] detail_one;

    assign health[BIT_BYPASS] = (status_s.bypass_detail_code == BYPASS_CLEAN);
    assign health[BIT_OVERCURRENT] = status_s.batt_overcurrent;
    assign health[BIT_PRESENT] = status_s.battery_present;
    assign health[BIT_BATTERY] = (status_s.battery_detail_code == BATT_OK_HIGH)
        || (status_s.battery_detail_code == BATT_OK_LOW);
    assign health[BIT_CHARGER] = CHG_GOOD_CODES[status_s.charger_detail_code];
    assign health[BIT_TOPOFF] = status_s.topoff_state;
    assign health[BIT_INPUT] = (status_s.input_detail_code == INPUT_VALID);
    assign health[BIT_MODE] = ~(status_s.adaptive_input_limit
        | status_s.input_current_limit_mode);

    // Input code passes through as the charger reports it
    assign detail_zero = {1'b0, status_s.input_detail_code, 2'b00,
        status_s.bus_below_threshold,
        status_s.overvoltage_switch_on,
        ~status_s.battery_present};
    assign detail_one = {1'b0, status_s.battery_detail_code, status_s.charger_detail_code};

    // Serial bus edge and condition detection
    logic scl_prev_ff;
    logic sda_prev_ff;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge I_CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_prev_ff <= scl_s;
            sda_prev_ff <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_prev_ff;
    assign scl_fall = ~scl_s & scl_prev_ff;
    assign bus_start = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
    assign bus_stop = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

    // Serial slave engine
    serial_state_t state_ff;
    serial_state_t nxt_state;
    logic [3:0] bits_ff;
    logic [3:0] nxt_bits;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [7:0] ptr_ff;
    logic [7:0] nxt_ptr;
    logic rw_ff;
    logic nxt_rw;
    logic nack_ff;
    logic nxt_nack;
    logic sda_oe_ff;
    logic nxt_sda_oe;
    logic sda_out_ff;
    logic wr_stb;
    logic rd_load;
    logic [7:0] rd_data;
    logic [7:0] ptr_inc;

    assign ptr_inc = ptr_ff + 8'h01;

    always_comb begin
        nxt_state = state_ff;
        nxt_bits = bits_ff;
        nxt_shift = shift_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_nack = nack_ff;
        nxt_sda_oe = sda_oe_ff;
        wr_stb = 1'b0;
        rd_load = 1'b0;
        if (bus_stop) begin
            nxt_state = ST_IDLE;
            nxt_sda_oe = 1'b0;
        end else if (bus_start) begin
            nxt_state = ST_DEV;
            nxt_bits = 4'h0;
            nxt_sda_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (state_ff)
                ST_DEV, ST_PTR, ST_WR: begin
                    nxt_shift = {shift_ff[6:0], sda_s};
                    nxt_bits = bits_ff + 4'h1;
                end
                ST_RD: begin
                    nxt_bits = bits_ff + 4'h1;
                end
                ST_RD_ACK: begin
                    nxt_nack = sda_s;
                end
                ST_IDLE, ST_DEV_ACK, ST_PTR_ACK, ST_WR_ACK: begin
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_ff)
                ST_DEV: begin
                    if (bits_ff == BITS_PER_BYTE) begin
                        if (shift_ff[7:1] == SLAVE_ADDR) begin
                            nxt_state = ST_DEV_ACK;
                            nxt_rw = shift_ff[0];
                            nxt_sda_oe = 1'b1;
                        end else begin
                            nxt_state = ST_IDLE;
                        end
                    end
                end
                ST_PTR: begin
                    if (bits_ff == BITS_PER_BYTE) begin
                        nxt_state = ST_PTR_ACK;
                        nxt_ptr = shift_ff;
                        nxt_sda_oe = 1'b1;
                    end
                end
                ST_WR: begin
                    if (bits_ff == BITS_PER_BYTE) begin
                        nxt_state = ST_WR_ACK;
                        nxt_sda_oe = 1'b1;
                        nxt_ptr = ptr_inc;
                        wr_stb = 1'b1;
                    end
                end
                ST_RD: begin
                    if (bits_ff == BITS_PER_BYTE) begin
                        nxt_state = ST_RD_ACK;
                        nxt_sda_oe = 1'b0;
                    end else begin
                        nxt_shift = {shift_ff[6:0], 1'b0};
                        nxt_sda_oe = ~shift_ff[6];
                    end
                end
                ST_DEV_ACK, ST_RD_ACK: begin
                    nxt_bits = 4'h0;
                    if ((state_ff == ST_DEV_ACK && rw_ff)
                        || (state_ff == ST_RD_ACK && !nack_ff)) begin
                        nxt_state = ST_RD;
                        nxt_shift = rd_data;
                        nxt_sda_oe = ~rd_data[7];
                        nxt_ptr = ptr_inc;
                        rd_load = 1'b1;
                    end else begin
                        nxt_state = (state_ff == ST_DEV_ACK) ? ST_PTR : ST_IDLE;
                        nxt_sda_oe = 1'b0;
                    end
                end
                ST_PTR_ACK, ST_WR_ACK: begin
                    nxt_state = ST_WR;
                    nxt_bits = 4'h0;
                    nxt_sda_oe = 1'b0;
                end
                ST_IDLE: begin
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= ST_IDLE;
            bits_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            nack_ff <= 1'b1;
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bits_ff <= nxt_bits;
            shift_ff <= nxt_shift;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            nack_ff <= nxt_nack;
            sda_oe_ff <= nxt_sda_oe;
            // Open drain: the line is only ever pulled low
            sda_out_ff <= 1'b0;
        end
    end

    // Pointer decode shared by read selection, clear and writes
    logic hit_flags;
    logic hit_masks;
    logic hit_health;
    logic hit_detail_zero;
    logic hit_detail_one;

    assign hit_flags = (ptr_ff == ADDR_EVENT_FLAGS);
    assign hit_masks = (ptr_ff == ADDR_EVENT_MASKS);
    assign hit_health = (ptr_ff == ADDR_HEALTH_FLAGS);
    assign hit_detail_zero = (ptr_ff == ADDR_DETAIL_ZERO);
    assign hit_detail_one = (ptr_ff == ADDR_DETAIL_ONE);

    // Event flags
    logic [7:0] event_flags;
    logic flags_clear;

    // The byte is captured for shifting in the same cycle as the clear
    assign flags_clear = rd_load && hit_flags;

    change_flags u_change_flags (
        .i_clk(I_CLOCK),
        .i_rst_n(rst_n_ff),
        .i_status(health),
        .i_clear(flags_clear),
        .o_flags(event_flags)
    );

    // Mask register
    logic [7:0] masks_ff;
    logic mask_wr;

    assign mask_wr = wr_stb && hit_masks;

    always_ff @(posedge I_CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            masks_ff <= RST_EVENT_MASKS;
        end else if (mask_wr) begin
            masks_ff <= shift_ff;
        end
    end

    // Static configuration, write protected by the lock input
    logic [7:0] cfg_ff [CFG_COUNT];
    logic [7:0] cfg_offset;
    logic [2:0] cfg_idx;
    logic cfg_hit;
    logic cfg_wr;

    assign cfg_offset = ptr_ff - ADDR_CFG_FIRST;
    assign cfg_hit = ((ptr_ff >= ADDR_CFG_FIRST) && (ptr_ff <= ADDR_CFG_LAST_RUN))
        || (ptr_ff == ADDR_CFG_SEVEN);
    assign cfg_idx = (ptr_ff == ADDR_CFG_SEVEN) ? 3'(CFG_SEVEN_INDEX) : cfg_offset[2:0];
    // Writes under lock are acknowledged but dropped
    assign cfg_wr = wr_stb && cfg_hit && !static_write_lock;

    genvar g;
    generate
        for (g = 0; g < CFG_COUNT; g++) begin : g_cfg
            always_ff @(posedge I_CLOCK or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    cfg_ff[g] <= RST_STATIC_CFG[g*8 +: 8];
                end else if (cfg_wr && (cfg_idx == 3'(g))) begin
                    cfg_ff[g] <= shift_ff;
                end
            end
            assign O_STATIC_CONFIG[g*8 +: 8] = cfg_ff[g];
        end
    endgenerate

    // Read selection; unmapped offsets read zero
    assign rd_data = hit_flags ? event_flags
        : hit_masks ? masks_ff
        : hit_health ? health
        : hit_detail_zero ? detail_zero
        : hit_detail_one ? detail_one
        : cfg_hit ? cfg_ff[cfg_idx]
        : 8'h00;

    // Interrupt outputs
    logic irq_n_ff;
    logic pending_ff;
    logic [7:0] live_events;
    logic any_pending;

    // Top pending ignores masks; only the pin honours them
    assign live_events = event_flags & ~masks_ff;
    assign any_pending = |event_flags;

    always_ff @(posedge I_CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            irq_n_ff <= 1'b1;
            pending_ff <= 1'b0;
        end else begin
            irq_n_ff <= ~|live_events;
            pending_ff <= any_pending;
        end
    end

    assign O_SDA_OUT = sda_out_ff;
    assign O_SDA_OE = sda_oe_ff;
    assign O_CHARGER_IRQ_N = irq_n_ff;
    assign O_TOP_CHARGER_PENDING = pending_ff;
endmodule

// file: bench/chg_ref.svh
// Reference health byte worked out from raw charger status
`ifndef CHG_REF_SVH
`define CHG_REF_SVH
function automatic logic [7:0] ref_health(input chg_irq_pkg::analog_status_t s);
    logic [7:0] h;
    h[0] = s.bypass_detail_code == 3'h0;
    h[1] = s.batt_overcurrent;
    h[2] = s.battery_present;
    h[3] = s.battery_detail_code inside {3'h3, 3'h4};
    h[4] = s.charger_detail_code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8};
    h[5] = s.topoff_state;
    h[6] = s.input_detail_code == 2'h3;
    h[7] = !(s.adaptive_input_limit || s.input_current_limit_mode);
    return h;
endfunction
`endif

// file: bench/i2c_host_model.sv
// Serial host master model for the charger register page
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    localparam int Q = 16;
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Data moves only inside the low phase, never read as start or stop
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        o_sda_pull = ~b;
        tick(Q);
        o_scl = 1'b1;
        tick(Q / 2);
        r = i_sda;
        tick(Q / 2);
        o_scl = 1'b0;
    endtask
    // Also serves as repeated start from a low clock
    task automatic start();
        tick(4);
        o_sda_pull = 1'b0;
        tick(Q);
        o_scl = 1'b1;
        tick(Q);
        o_sda_pull = 1'b1;
        tick(Q);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        tick(4);
        o_sda_pull = 1'b1;
        tick(Q);
        o_scl = 1'b1;
        tick(Q);
        o_sda_pull = 1'b0;
        tick(Q);
    endtask
    task automatic put(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, nak);
    endtask
    // Single byte reads only, so the acknowledge slot is always a release
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, r);
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d,
        output logic nak);
        logic k0, k1, k2;
        start();
        put(dev, k0);
        put(a, k1);
        put(d, k2);
        stop();
        nak = k0 | k1 | k2;
    endtask
    task automatic rd(input logic [7:0] dev, input logic [7:0] a, output logic [7:0] d);
        logic k;
        start();
        put(dev, k);
        put(a, k);
        start();
        put(dev | 8'h01, k);
        get(d);
        stop();
    endtask
endmodule

// file: bench/charger_bank_sva.sv
// Port-level assertions for the charger interrupt and status bank
`timescale 1ns/1ps
`include "chg_ref.svh"
module charger_bank_sva
    import chg_irq_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire analog_status_t I_ANALOG_STATUS,
    input wire logic I_STATIC_WRITE_LOCK,
    input wire logic I_SCL,
    input wire logic O_CHARGER_IRQ_N,
    input wire logic O_TOP_CHARGER_PENDING,
    input wire logic [47:0] O_STATIC_CONFIG
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_NRST);
    logic [7:0] health;
    logic [7:0] chg_age_ff;
    logic [7:0] fall_age_ff;
    logic [7:0] rises_ff;
    logic [7:0] lock_age_ff;
    function automatic logic [7:0] inc(input logic [7:0] x);
        return (x == 8'hFF) ? x : x + 8'h01;
    endfunction
    assign health = ref_health(I_ANALOG_STATUS);
    // Ages saturate so long idle spans never wrap into false recency
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            chg_age_ff <= 8'h00;
            fall_age_ff <= 8'hFF;
            rises_ff <= 8'h00;
            lock_age_ff <= 8'h00;
        end else begin
            chg_age_ff <= $changed(I_ANALOG_STATUS) ? 8'h00 : inc(chg_age_ff);
            fall_age_ff <= $fell(I_SCL) ? 8'h00 : inc(fall_age_ff);
            rises_ff <= $rose(I_SCL) ? inc(rises_ff) : rises_ff;
            lock_age_ff <= I_STATIC_WRITE_LOCK ? inc(lock_age_ff) : 8'h00;
        end
    end
    property p_pin_pending;
        !O_TOP_CHARGER_PENDING |-> O_CHARGER_IRQ_N;
    endproperty
    a_pin_pending: assert property (p_pin_pending) else $error("pin low, nothing pending");
    // No full write frame yet, so every mask still holds its reset one
    property p_masks_reset;
        rises_ff < 8'h1B |-> O_CHARGER_IRQ_N;
    endproperty
    a_masks_reset: assert property (p_masks_reset) else $error("pin low before any write");
    property p_cfg_locked;
        lock_age_ff >= 8'h08 |-> $stable(O_STATIC_CONFIG);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("config moved while locked");
    property p_cfg_timing;
        $changed(O_STATIC_CONFIG) |-> fall_age_ff <= 8'h0C;
    endproperty
    a_cfg_timing: assert property (p_cfg_timing) else $error("config moved off a write");
    property p_event_cause;
        $rose(O_TOP_CHARGER_PENDING) |-> chg_age_ff <= 8'h14;
    endproperty
    a_event_cause: assert property (p_event_cause) else $error("event with no change");
    property p_change_sets;
        $changed(health) |-> ##[1:20] O_TOP_CHARGER_PENDING;
    endproperty
    a_change_sets: assert property (p_change_sets) else $error("health change lost");
    property p_pending_fell;
        $fell(O_TOP_CHARGER_PENDING) |-> fall_age_ff <= 8'h0C;
    endproperty
    a_pending_fell: assert property (p_pending_fell) else $error("pending dropped unread");
    property p_pending_held;
        O_TOP_CHARGER_PENDING && fall_age_ff > 8'h0C |=> O_TOP_CHARGER_PENDING;
    endproperty
    a_pending_held: assert property (p_pending_held) else $error("pending not held");
    c_event: cover property ($rose(O_TOP_CHARGER_PENDING));
    c_pin: cover property ($fell(O_CHARGER_IRQ_N));
    c_cfg: cover property ($changed(O_STATIC_CONFIG));
endmodule
bind charger_interrupt_status_bank charger_bank_sva chk (.I_CLOCK, .I_NRST, .I_ANALOG_STATUS,
    .I_STATIC_WRITE_LOCK, .I_SCL, .O_CHARGER_IRQ_N, .O_TOP_CHARGER_PENDING, .O_STATIC_CONFIG);

// file: bench/tb_charger_interrupt_status_bank.sv
// Self-checking bench for the charger interrupt and status bank
`timescale 1ns/1ps
`include "chg_ref.svh"
module tb_charger_interrupt_status_bank
    import chg_irq_pkg::*;
;
    localparam logic [7:0] DEV_W = {SLAVE_ADDR, 1'b0};
    localparam logic [18:0] VEC [7] = '{19'h00000, 19'h05AB0, 19'h2E43A, 19'h02B65,
        19'h07890, 19'h00100, 19'h099B0};
    logic i_clock = 1'b0;
    logic i_nrst;
    logic lock;
    logic scl;
    logic pull;
    logic sda_oe;
    logic sda_out;
    logic irq_n;
    logic pending;
    logic nak;
    logic [7:0] mask;
    logic [7:0] prev;
    logic [7:0] rdata;
    logic [47:0] cfg;
    analog_status_t status;
    int error_cnt = 0;
    int n_compared = 0;
    // Pulled-up open-drain data line
    wire sda = ~(pull | sda_oe);
    always #10 i_clock = ~i_clock;
    charger_interrupt_status_bank uut (
        .I_CLOCK(i_clock), .I_NRST(i_nrst), .I_ANALOG_STATUS(status),
        .I_STATIC_WRITE_LOCK(lock), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
        .O_SDA_OE(sda_oe), .O_CHARGER_IRQ_N(irq_n), .O_TOP_CHARGER_PENDING(pending),
        .O_STATIC_CONFIG(cfg)
    );
    i2c_host_model host (.i_clk(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host.rd(DEV_W, a, rdata);
        check8(what, exp, rdata);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.wr(DEV_W, a, d, nak);
        check8("write ack", 8'h00, {7'h00, nak});
    endtask
    // Flags expected are all health bits moved since the previous read
    task automatic step(input logic [18:0] v);
        analog_status_t s;
        logic [7:0] h;
        s = analog_status_t'(v);
        h = ref_health(s);
        @(negedge i_clock);
        status = s;
        repeat (20) @(negedge i_clock);
        check8("pending", {7'h00, |(prev ^ h)}, {7'h00, pending});
        check8("pin", {7'h00, ~|((prev ^ h) & ~mask)}, {7'h00, irq_n});
        rd_chk("health", ADDR_HEALTH_FLAGS, h);
        rd_chk("detail zero", ADDR_DETAIL_ZERO, {1'b0, s.input_detail_code, 2'b00,
            s.bus_below_threshold, s.overvoltage_switch_on, ~s.battery_present});
        rd_chk("detail one", ADDR_DETAIL_ONE, {1'b0, s.battery_detail_code,
            s.charger_detail_code});
        rd_chk("flags", ADDR_EVENT_FLAGS, prev ^ h);
        check8("pending cleared", 8'h00, {7'h00, pending});
        prev = h;
    endtask
    initial begin
        i_nrst = 1'b0;
        lock = 1'b0;
        status = '0;
        mask = 8'hFF;
        // Filter resets to zero status, so its health is the no-event baseline
        prev = ref_health(status);
        repeat (8) @(negedge i_clock);
        i_nrst = 1'b1;
        repeat (20) @(negedge i_clock);
        host.wr(8'hA4, ADDR_EVENT_MASKS, 8'h00, nak);
        check8("foreign address ack", 8'h01, {7'h00, nak});
        check8("sda drive level", 8'h00, {7'h00, sda_out});
        rd_chk("masks", ADDR_EVENT_MASKS, 8'hFF);
        rd_chk("unmapped", 8'hC0, 8'h00);
        step(VEC[0]);
        wr(ADDR_CFG_FIRST, 8'h5A);
        wr(ADDR_CFG_SEVEN, 8'h77);
        lock = 1'b1;
        wr(ADDR_CFG_FIRST, 8'h33);
        wr(ADDR_CFG_SEVEN, 8'h11);
        check8("cfg first", 8'h5A, cfg[7:0]);
        check8("cfg seventh", 8'h77, cfg[47:40]);
        mask = 8'hFE;
        wr(ADDR_EVENT_MASKS, mask);
        rd_chk("masks", ADDR_EVENT_MASKS, mask);
        wr(ADDR_EVENT_FLAGS, 8'hFF);
        wr(ADDR_HEALTH_FLAGS, 8'h00);
        for (int i = 1; i < 7; i++) begin
            step(VEC[i]);
        end
        report_and_stop();
    end
    initial begin
        repeat (95000) @(posedge i_clock);
        error_cnt++;
        report_and_stop();
    end
endmodule
